/* logic/uaux_params.svh */
`ifndef UAUX_PARAMS_SVH
`define UAUX_PARAMS_SVH

// register byte offsets
`define UAUX_OFS_PULL_HIGH 8'h00
`define UAUX_OFS_PULL_LOW 8'h04
`define UAUX_OFS_ECHO 8'h08
`define UAUX_OFS_TX_FLUSH 8'h0c
`define UAUX_OFS_TX_LEVEL 8'h10
`define UAUX_OFS_RX_FLUSH 8'h14
`define UAUX_OFS_RX_LEVEL 8'h18
`define UAUX_OFS_LATENCY 8'h1c
`define UAUX_OFS_WIDE 8'h20

// field positions
`define UAUX_BIT_GPIO_MSB 5
`define UAUX_BIT_RX_PIN 6
`define UAUX_BIT_TX_PIN 7
`define UAUX_BIT_ECHO_DATA 0
`define UAUX_BIT_ECHO_RTS 1
`define UAUX_BIT_ECHO_DTR 2
`define UAUX_BIT_FLUSH 0
`define UAUX_BIT_LOW_LAT 0
`define UAUX_BIT_WIDE 0

// reset values
`define UAUX_RST_PULL 8'h00
`define UAUX_RST_ECHO 3'h0
`define UAUX_RST_LOW_LAT 1'b0
`define UAUX_RST_WIDE 1'b0

// forwarding thresholds and counts
`define UAUX_LOW_BAUD_LIMIT 24'd40961
`define UAUX_PKT_BYTES 7'd64
`define UAUX_PKT_BYTES_ACM 7'd63
`define UAUX_IDLE_CHARS 2'd3

`endif

/* logic/uaux_pkg.sv */
package uaux_pkg;

  typedef enum logic [1:0] {
    UAUX_OKAY = 2'b00,
    UAUX_SLVERR = 2'b10
  } uaux_resp_t;

  typedef enum logic [3:0] {
    UAUX_REG_PULL_HIGH = 4'h0,
    UAUX_REG_PULL_LOW = 4'h1,
    UAUX_REG_ECHO = 4'h2,
    UAUX_REG_TX_FLUSH = 4'h3,
    UAUX_REG_TX_LEVEL = 4'h4,
    UAUX_REG_RX_FLUSH = 4'h5,
    UAUX_REG_RX_LEVEL = 4'h6,
    UAUX_REG_LATENCY = 4'h7,
    UAUX_REG_WIDE = 4'h8,
    UAUX_REG_NONE = 4'hf
  } uaux_reg_t;

endpackage

/* logic/uaux_top.sv */
// Implementation choices: the address map and the AXI4-Lite register port.
`include "uaux_params.svh"

// Function
// - tx pin pull-up follows pull-high register bit 7.
// - gpio pull-downs follow pull-low register bits 5:0.
// - rx pin pull-down follows pull-low register bit 6.
// - tx pin pull-down follows pull-low register bit 7.
// - data echo routes transmitter into receiver, pin rx ignored, tx pin held at mark.
// - rts echo feeds rts back as cts.
// - dtr echo feeds dtr back as dsr.
// - writing one to tx flush empties tx queue; write-only, self-clearing.
// - tx level register bits 7:0 report tx queue occupancy.
// - writing one to rx flush empties rx queue; write-only, self-clearing.
// - rx level register bits 8:0 report rx queue occupancy.
// - low latency forced high while baud rate below 40961.
// - without low latency hold rx data for full packet or 3-char idle.
// - with low latency forward each received character at once.
// - wide register bit 0 selects wide data mode.
// - rx pin pull-up follows pull-high register bit 6.
module uaux_top #(
  parameter int DW = 9,
  parameter int TX_DEPTH = 128,
  parameter int RX_DEPTH = 384
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host data into tx queue
  input wire logic tx_in_valid,
  input wire logic [DW-1:0] tx_in_data,
  output logic tx_in_ready,
  // tx queue to serializer
  output logic tx_out_valid,
  output logic [DW-1:0] tx_out_data,
  input wire logic tx_out_ready,
  // deserializer into rx queue
  input wire logic rx_in_valid,
  input wire logic [DW-1:0] rx_in_data,
  // rx queue toward host
  output logic rx_out_valid,
  output logic [DW-1:0] rx_out_data,
  input wire logic rx_out_ready,
  // line settings from line-coding logic
  input wire logic [23:0] baud_rate_bps,
  input wire logic char_tick,
  input wire logic acm_driver,
  output logic wide_mode_en,
  output logic low_latency_en,
  // serial core side
  input wire logic ser_txd,
  output logic rxd_core,
  input wire logic rts_core,
  output logic cts_core,
  input wire logic dtr_core,
  output logic dsr_core,
  // pins
  output logic txd_pin,
  input wire logic rxd_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  // pad pull controls
  output logic [5:0] gpio_pull_up,
  output logic [5:0] gpio_pull_dn,
  output logic rx_pull_up,
  output logic rx_pull_dn,
  output logic tx_pull_up,
  output logic tx_pull_dn
);

  localparam int TPW = $clog2(TX_DEPTH);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  initial begin
    if (TX_DEPTH < 2 || TX_DEPTH > 255 || RX_DEPTH < 64 || RX_DEPTH > 511 ||
        DW < 7 || DW > 32) begin
      $error("uaux_top: unsupported depth or width");
    end
  end

  typedef struct packed {
    logic [7:0] pu;
    logic [7:0] pd;
    logic [2:0] lb;
    logic ll;
    logic wide;
    logic [TX_DEPTH-1:0][DW-1:0] tx_mem;
    logic [TPW-1:0] tx_wp;
    logic [TPW-1:0] tx_rp;
    logic [TCW-1:0] tx_cnt;
    logic [RX_DEPTH-1:0][DW-1:0] rx_mem;
    logic [RPW-1:0] rx_wp;
    logic [RPW-1:0] rx_rp;
    logic [RCW-1:0] rx_cnt;
    logic [6:0] burst;
    logic [1:0] idle;
    logic tmo;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] s_rx;
    logic [2:0] s_cts;
    logic [2:0] s_dsr;
    logic rx_f;
    logic cts_f;
    logic dsr_f;
    logic txd_o;
    logic rxd_o;
  } uaux_st_t;

  uaux_st_t st_r;
  uaux_st_t st_nxt;

  function automatic uaux_pkg::uaux_reg_t uaux_decode(input logic [7:0] a);
    case (a)
      `UAUX_OFS_PULL_HIGH: uaux_decode = uaux_pkg::UAUX_REG_PULL_HIGH;
      `UAUX_OFS_PULL_LOW: uaux_decode = uaux_pkg::UAUX_REG_PULL_LOW;
      `UAUX_OFS_ECHO: uaux_decode = uaux_pkg::UAUX_REG_ECHO;
      `UAUX_OFS_TX_FLUSH: uaux_decode = uaux_pkg::UAUX_REG_TX_FLUSH;
      `UAUX_OFS_TX_LEVEL: uaux_decode = uaux_pkg::UAUX_REG_TX_LEVEL;
      `UAUX_OFS_RX_FLUSH: uaux_decode = uaux_pkg::UAUX_REG_RX_FLUSH;
      `UAUX_OFS_RX_LEVEL: uaux_decode = uaux_pkg::UAUX_REG_RX_LEVEL;
      `UAUX_OFS_LATENCY: uaux_decode = uaux_pkg::UAUX_REG_LATENCY;
      `UAUX_OFS_WIDE: uaux_decode = uaux_pkg::UAUX_REG_WIDE;
      default: uaux_decode = uaux_pkg::UAUX_REG_NONE;
    endcase
  endfunction

  // a change counts once the last two stages agree
  function automatic logic uaux_filt(input logic [2:0] s, input logic cur);
    uaux_filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  uaux_pkg::uaux_reg_t widx;
  uaux_pkg::uaux_reg_t ridx;
  logic wr_go;
  logic rd_go;
  logic low_baud;
  logic ll_eff;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic tx_flush;
  logic rx_flush;
  logic [6:0] pkt;

  assign widx = uaux_decode(s_axi_awaddr);
  assign ridx = uaux_decode(s_axi_araddr);
  // address and data are taken together, one write in flight
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign rd_go = s_axi_arvalid && !st_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  assign low_baud = baud_rate_bps < `UAUX_LOW_BAUD_LIMIT;
  assign ll_eff = st_r.ll || low_baud;
  assign pkt = acm_driver ? `UAUX_PKT_BYTES_ACM : `UAUX_PKT_BYTES;

  // flush takes effect only when byte lane 0 is written
  assign tx_flush = wr_go && s_axi_wstrb[0] && s_axi_wdata[`UAUX_BIT_FLUSH] &&
                    widx == uaux_pkg::UAUX_REG_TX_FLUSH;
  assign rx_flush = wr_go && s_axi_wstrb[0] && s_axi_wdata[`UAUX_BIT_FLUSH] &&
                    widx == uaux_pkg::UAUX_REG_RX_FLUSH;

  assign tx_in_ready = (st_r.tx_cnt != TCW'(TX_DEPTH)) && !tx_flush;
  assign tx_out_valid = st_r.tx_cnt != '0;
  assign tx_out_data = st_r.tx_mem[st_r.tx_rp];
  assign tx_push = tx_in_valid && tx_in_ready;
  assign tx_pop = tx_out_valid && tx_out_ready && !tx_flush;

  // hold back until low latency, a full packet, or idle timeout
  assign rx_out_valid = (st_r.rx_cnt != '0) &&
                        (ll_eff || st_r.burst != '0 || st_r.tmo);
  assign rx_out_data = st_r.rx_mem[st_r.rx_rp];
  // the receiver cannot stall, so a full queue drops the character
  assign rx_push = rx_in_valid && (st_r.rx_cnt != RCW'(RX_DEPTH)) && !rx_flush;
  assign rx_pop = rx_out_valid && rx_out_ready && !rx_flush;

  assign gpio_pull_up = st_r.pu[`UAUX_BIT_GPIO_MSB:0];
  assign rx_pull_up = st_r.pu[`UAUX_BIT_RX_PIN];
  assign tx_pull_up = st_r.pu[`UAUX_BIT_TX_PIN];
  assign gpio_pull_dn = st_r.pd[`UAUX_BIT_GPIO_MSB:0];
  assign rx_pull_dn = st_r.pd[`UAUX_BIT_RX_PIN];
  assign tx_pull_dn = st_r.pd[`UAUX_BIT_TX_PIN];
  assign wide_mode_en = st_r.wide;
  assign low_latency_en = ll_eff;
  assign txd_pin = st_r.txd_o;
  assign rxd_core = st_r.rxd_o;
  assign cts_core = st_r.lb[`UAUX_BIT_ECHO_RTS] ? rts_core : st_r.cts_f;
  assign dsr_core = st_r.lb[`UAUX_BIT_ECHO_DTR] ? dtr_core : st_r.dsr_f;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s_rx = {st_r.s_rx[1:0], rxd_pin};
    st_nxt.s_cts = {st_r.s_cts[1:0], cts_pin};
    st_nxt.s_dsr = {st_r.s_dsr[1:0], dsr_pin};
    st_nxt.rx_f = uaux_filt(st_r.s_rx, st_r.rx_f);
    st_nxt.cts_f = uaux_filt(st_r.s_cts, st_r.cts_f);
    st_nxt.dsr_f = uaux_filt(st_r.s_dsr, st_r.dsr_f);
    // pin stays at mark and pin input is ignored during data echo
    st_nxt.txd_o = st_r.lb[`UAUX_BIT_ECHO_DATA] ? 1'b1 : ser_txd;
    st_nxt.rxd_o = st_r.lb[`UAUX_BIT_ECHO_DATA] ? ser_txd : st_r.rx_f;

    // register writes; reserved bits are simply not stored
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = uaux_pkg::UAUX_OKAY;
      if (s_axi_wstrb[0]) begin
        case (widx)
          uaux_pkg::UAUX_REG_PULL_HIGH: st_nxt.pu = s_axi_wdata[7:0];
          uaux_pkg::UAUX_REG_PULL_LOW: st_nxt.pd = s_axi_wdata[7:0];
          uaux_pkg::UAUX_REG_ECHO: st_nxt.lb = s_axi_wdata[2:0];
          uaux_pkg::UAUX_REG_LATENCY: st_nxt.ll = s_axi_wdata[`UAUX_BIT_LOW_LAT];
          uaux_pkg::UAUX_REG_WIDE: st_nxt.wide = s_axi_wdata[`UAUX_BIT_WIDE];
          default: st_nxt.bresp = st_nxt.bresp;
        endcase
      end
      if (widx == uaux_pkg::UAUX_REG_NONE || widx == uaux_pkg::UAUX_REG_TX_LEVEL ||
          widx == uaux_pkg::UAUX_REG_RX_LEVEL) begin
        st_nxt.bresp = uaux_pkg::UAUX_SLVERR;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // forcing wins over a software clear of the same bit
    if (low_baud) begin
      st_nxt.ll = 1'b1;
    end

    // register reads; flush registers read as zero
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = uaux_pkg::UAUX_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (ridx)
        uaux_pkg::UAUX_REG_PULL_HIGH: st_nxt.rdata[7:0] = st_r.pu;
        uaux_pkg::UAUX_REG_PULL_LOW: st_nxt.rdata[7:0] = st_r.pd;
        uaux_pkg::UAUX_REG_ECHO: st_nxt.rdata[2:0] = st_r.lb;
        uaux_pkg::UAUX_REG_TX_LEVEL: st_nxt.rdata[7:0] = 8'(st_r.tx_cnt);
        uaux_pkg::UAUX_REG_RX_LEVEL: st_nxt.rdata[8:0] = 9'(st_r.rx_cnt);
        uaux_pkg::UAUX_REG_LATENCY: st_nxt.rdata[0] = ll_eff;
        uaux_pkg::UAUX_REG_WIDE: st_nxt.rdata[0] = st_r.wide;
        uaux_pkg::UAUX_REG_TX_FLUSH,
        uaux_pkg::UAUX_REG_RX_FLUSH: st_nxt.rdata = 32'h0000_0000;
        default: st_nxt.rresp = uaux_pkg::UAUX_SLVERR;
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // tx queue
    if (tx_push) begin
      st_nxt.tx_mem[st_r.tx_wp] = tx_in_data;
      st_nxt.tx_wp = (st_r.tx_wp == TPW'(TX_DEPTH - 1)) ? '0 : st_r.tx_wp + 1'b1;
    end
    if (tx_pop) begin
      st_nxt.tx_rp = (st_r.tx_rp == TPW'(TX_DEPTH - 1)) ? '0 : st_r.tx_rp + 1'b1;
    end
    if (tx_push && !tx_pop) begin
      st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
    end else if (tx_pop && !tx_push) begin
      st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
    end
    if (tx_flush) begin
      st_nxt.tx_wp = '0;
      st_nxt.tx_rp = '0;
      st_nxt.tx_cnt = '0;
    end

    // rx queue
    if (rx_push) begin
      st_nxt.rx_mem[st_r.rx_wp] = rx_in_data;
      st_nxt.rx_wp = (st_r.rx_wp == RPW'(RX_DEPTH - 1)) ? '0 : st_r.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      st_nxt.rx_rp = (st_r.rx_rp == RPW'(RX_DEPTH - 1)) ? '0 : st_r.rx_rp + 1'b1;
    end
    if (rx_push && !rx_pop) begin
      st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
    end else if (rx_pop && !rx_push) begin
      st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
    end

    // packet release: a full packet is drained as one burst
    if (rx_pop && st_r.burst != '0) begin
      st_nxt.burst = st_r.burst - 1'b1;
    end else if (st_r.burst == '0 && !ll_eff && st_r.rx_cnt >= RCW'(pkt)) begin
      st_nxt.burst = pkt;
    end
    // idle timeout counted in character times since the last arrival
    if (rx_push) begin
      st_nxt.idle = '0;
      st_nxt.tmo = 1'b0;
    end else if (st_r.rx_cnt == '0) begin
      st_nxt.idle = '0;
      st_nxt.tmo = 1'b0;
    end else if (char_tick && !st_r.tmo) begin
      st_nxt.idle = st_r.idle + 1'b1;
      st_nxt.tmo = (st_r.idle + 1'b1) == `UAUX_IDLE_CHARS;
    end
    if (rx_flush) begin
      st_nxt.rx_wp = '0;
      st_nxt.rx_rp = '0;
      st_nxt.rx_cnt = '0;
      st_nxt.burst = '0;
      st_nxt.idle = '0;
      st_nxt.tmo = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.pu <= `UAUX_RST_PULL;
      st_r.pd <= `UAUX_RST_PULL;
      st_r.lb <= `UAUX_RST_ECHO;
      st_r.ll <= `UAUX_RST_LOW_LAT;
      st_r.wide <= `UAUX_RST_WIDE;
      st_r.s_rx <= 3'h7;
      st_r.s_cts <= 3'h7;
      st_r.s_dsr <= 3'h7;
      st_r.rx_f <= 1'b1;
      st_r.cts_f <= 1'b1;
      st_r.dsr_f <= 1'b1;
      st_r.txd_o <= 1'b1;
      st_r.rxd_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_tx_pin_mark: assert property ($past(st_r.lb[0]) |-> txd_pin)
    else $error("tx pin not at mark during data echo");
  a_rx_echo_path: assert property ($past(st_r.lb[0]) |-> rxd_core == $past(ser_txd))
    else $error("receiver not fed from transmitter during echo");
  a_cts_echo: assert property (st_r.lb[1] |-> cts_core == rts_core)
    else $error("cts does not follow rts in echo");
  a_dsr_echo: assert property (st_r.lb[2] |-> dsr_core == dtr_core)
    else $error("dsr does not follow dtr in echo");
  a_tx_flush_empty: assert property (tx_flush |=> st_r.tx_cnt == '0 && !tx_out_valid)
    else $error("tx queue not empty after flush");
  a_rx_flush_empty: assert property (rx_flush |=> st_r.rx_cnt == '0 ##1 st_r.rx_cnt <= 1)
    else $error("rx queue not empty after flush");
  a_tx_level_read: assert property (rd_go && ridx == uaux_pkg::UAUX_REG_TX_LEVEL
      |=> s_axi_rvalid && s_axi_rdata == 32'($past(st_r.tx_cnt)))
    else $error("tx level read mismatch");
  a_rx_level_read: assert property (rd_go && ridx == uaux_pkg::UAUX_REG_RX_LEVEL
      |=> s_axi_rdata[8:0] == 9'($past(st_r.rx_cnt)))
    else $error("rx level read mismatch");
  a_rx_cap_drop: assert property (st_r.rx_cnt == RCW'(RX_DEPTH) && !rx_pop && !rx_flush
      |=> st_r.rx_cnt == RCW'(RX_DEPTH))
    else $error("rx level past capacity");
  a_low_baud_force: assert property (low_baud |=> st_r.ll && low_latency_en)
    else $error("low latency not forced at low baud");
  a_rx_hold: assert property (rx_out_valid && !ll_eff |-> st_r.burst != '0 || st_r.tmo)
    else $error("rx data released early");
  a_rx_immediate: assert property (ll_eff && st_r.rx_cnt != '0 |-> rx_out_valid)
    else $error("rx data held in low latency");
  a_pad_pulls: assert property (wr_go && s_axi_wstrb[0] &&
      widx == uaux_pkg::UAUX_REG_PULL_LOW
      |=> {tx_pull_dn, rx_pull_dn, gpio_pull_dn} == $past(s_axi_wdata[7:0]))
    else $error("pad pull mismatch");
  a_wide_write: assert property (wr_go && s_axi_wstrb[0] && widx == uaux_pkg::UAUX_REG_WIDE
      |=> wide_mode_en == $past(s_axi_wdata[0]))
    else $error("wide mode not updated");

endmodule

/* tb/test_uart_aux_control.sv */
module test_uart_aux_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // ready held high: every answer is taken at once
  logic bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic tx_in_valid = 1'b0, tx_out_ready = 1'b0, rx_in_valid = 1'b0, rx_out_ready = 1'b0;
  logic char_tick = 1'b0, acm_driver = 1'b0;
  logic [8:0] tx_in_data = 9'h000, rx_in_data = 9'h000;
  logic tx_in_ready, tx_out_valid, rx_out_valid;
  logic [8:0] tx_out_data, rx_out_data;
  logic [23:0] baud = 24'd115200;
  logic wide_mode_en, low_latency_en;
  logic ser_txd = 1'b1, rts_core = 1'b0, dtr_core = 1'b0, cts_lvl = 1'b1, dsr_lvl = 1'b1;
  logic rxd_core, cts_core, dsr_core, txd_pin, rxd_pin, cts_pin, dsr_pin;
  logic [5:0] gpio_pull_up, gpio_pull_dn;
  logic rx_pull_up, rx_pull_dn, tx_pull_up, tx_pull_dn;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 33;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [8:0] exp_tx[$], exp_rx[$];
  logic [33:0] note;
  logic [31:0] rv;

  uaux_top dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid),
    .rx_out_data(rx_out_data), .rx_out_ready(rx_out_ready), .baud_rate_bps(baud),
    .char_tick(char_tick), .acm_driver(acm_driver), .wide_mode_en(wide_mode_en),
    .low_latency_en(low_latency_en), .ser_txd(ser_txd), .rxd_core(rxd_core),
    .rts_core(rts_core), .cts_core(cts_core), .dtr_core(dtr_core), .dsr_core(dsr_core),
    .txd_pin(txd_pin), .rxd_pin(rxd_pin), .cts_pin(cts_pin), .dsr_pin(dsr_pin),
    .gpio_pull_up(gpio_pull_up), .gpio_pull_dn(gpio_pull_dn), .rx_pull_up(rx_pull_up),
    .rx_pull_dn(rx_pull_dn), .tx_pull_up(tx_pull_up), .tx_pull_dn(tx_pull_dn));

  uaux_remote_model remote (.clk(clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
    .cts_pin(cts_pin), .dsr_pin(dsr_pin), .cts_lvl(cts_lvl), .dsr_lvl(dsr_lvl));

  always #2 clk = ~clk;

  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // oldest note against each result as it appears
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp("bresp", 32'(exp_b.pop_front()), 32'(bresp));
    if (rvalid === 1'b1 && rready === 1'b1) begin
      note = exp_r.pop_front();
      cmp("rresp", 32'(note[33:32]), 32'(rresp));
      cmp("rdata", note[31:0], rdata);
    end
    if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
      cmp("tx char", 32'(exp_tx.pop_front()), 32'(tx_out_data));
    end
    if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) begin
      cmp("rx char", 32'(exp_rx.pop_front()), 32'(rx_out_data));
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    exp_b.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] d);
    @(posedge clk);
    exp_r.push_back({e, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
  endtask

  task push_tx(input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rv = $random(seed);
      tx_in_data <= rv[8:0];
      tx_in_valid <= 1'b1;
      exp_tx.push_back(rv[8:0]);
      do @(negedge clk); while (tx_in_ready !== 1'b1);
      @(posedge clk);
    end
    tx_in_valid <= 1'b0;
  endtask

  task push_rx(input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rv = $random(seed);
      rx_in_data <= rv[8:0];
      rx_in_valid <= 1'b1;
      exp_rx.push_back(rv[8:0]);
      @(posedge clk);
    end
    rx_in_valid <= 1'b0;
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      char_tick <= 1'b1;
      @(posedge clk);
      char_tick <= 1'b0;
    end
  endtask

  task wait_look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task done_test(input string name);
    $display("test %s finished", name);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rd(8'(a), (a == 36) ? 2'b10 : 2'b00, 32'h0);
    wr(8'h24, 32'h1, 2'b10);
    wr(8'h10, 32'h5, 2'b10);
    rd(8'h10, 2'b00, 32'h0);
    done_test("map");
    rv = $random(seed);
    // complement in the low register keeps each pin to one pull
    wr(8'h00, {24'h0, rv[7:0]}, 2'b00);
    wr(8'h04, {24'h0, ~rv[7:0]}, 2'b00);
    wait_look(1);
    cmp("pull up", 32'(rv[7:0]), 32'({tx_pull_up, rx_pull_up, gpio_pull_up}));
    cmp("pull dn", {24'h0, ~rv[7:0]}, 32'({tx_pull_dn, rx_pull_dn, gpio_pull_dn}));
    rd(8'h00, 2'b00, {24'h0, rv[7:0]});
    rd(8'h04, 2'b00, {24'h0, ~rv[7:0]});
    done_test("pulls");
    wr(8'h08, 32'h7, 2'b00);
    @(posedge clk);
    ser_txd <= 1'b0;
    rts_core <= 1'b1;
    wait_look(3);
    cmp("echo txd", 32'h1, 32'(txd_pin));
    cmp("echo rxd", 32'h0, 32'(rxd_core));
    cmp("echo cts", 32'h1, 32'(cts_core));
    cmp("echo dsr", 32'h0, 32'(dsr_core));
    rd(8'h08, 2'b00, 32'h7);
    wr(8'h08, 32'h0, 2'b00);
    @(posedge clk);
    cts_lvl <= 1'b0;
    wait_look(10);
    cmp("pin txd", 32'h0, 32'(txd_pin));
    cmp("pin rxd", 32'h0, 32'(rxd_core));
    cmp("pin cts", 32'h0, 32'(cts_core));
    cmp("pin dsr", 32'h1, 32'(dsr_core));
    @(posedge clk);
    ser_txd <= 1'b1;
    done_test("echo");
    push_tx(5);
    rd(8'h10, 2'b00, 32'd5);
    @(posedge clk);
    tx_out_ready <= 1'b1;
    repeat (2) @(posedge clk);
    tx_out_ready <= 1'b0;
    rd(8'h10, 2'b00, 32'd3);
    wr(8'h0c, 32'h1, 2'b00);
    exp_tx.delete();
    rd(8'h10, 2'b00, 32'd0);
    push_tx(128);
    wait_look(1);
    cmp("tx full", 32'h0, 32'(tx_in_ready));
    rd(8'h10, 2'b00, 32'd128);
    wr(8'h0c, 32'h1, 2'b00);
    exp_tx.delete();
    rd(8'h0c, 2'b00, 32'd0);
    done_test("tx queue");
    @(posedge clk);
    rx_out_ready <= 1'b1;
    acm_driver <= 1'b1;
    push_rx(62);
    wait_look(4);
    cmp("held", 32'h0, 32'(rx_out_valid));
    push_rx(1);
    wait_look(80);
    cmp("burst", 32'h0, 32'(exp_rx.size()));
    push_rx(3);
    ticks(2);
    wait_look(4);
    cmp("idle wait", 32'h0, 32'(rx_out_valid));
    ticks(1);
    wait_look(8);
    cmp("idle out", 32'h0, 32'(exp_rx.size()));
    wr(8'h1c, 32'h1, 2'b00);
    push_rx(2);
    wait_look(3);
    cmp("low lat", 32'h0, 32'(exp_rx.size()));
    @(posedge clk);
    rx_out_ready <= 1'b0;
    // more than the queue holds: the surplus is dropped
    push_rx(390);
    rd(8'h18, 2'b00, 32'd384);
    wr(8'h14, 32'h1, 2'b00);
    exp_rx.delete();
    rd(8'h18, 2'b00, 32'd0);
    done_test("rx queue");
    wr(8'h1c, 32'h0, 2'b00);
    @(posedge clk);
    baud <= 24'd40960;
    rd(8'h1c, 2'b00, 32'h1);
    cmp("forced", 32'h1, 32'(low_latency_en));
    @(posedge clk);
    baud <= 24'd40961;
    wr(8'h1c, 32'h0, 2'b00);
    rd(8'h1c, 2'b00, 32'h0);
    wr(8'h20, 32'h1, 2'b00);
    wait_look(1);
    cmp("wide", 32'h1, 32'(wide_mode_en));
    rd(8'h20, 2'b00, 32'h1);
    done_test("latency wide");
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
endmodule

/* tb/uaux_remote_model.sv */
module uaux_remote_model (
  // clock
  input wire logic clk,
  // line from the device
  input wire logic txd_pin,
  // lines toward the device
  output logic rxd_pin,
  output logic cts_pin,
  output logic dsr_pin,
  // levels set by the bench
  input wire logic cts_lvl,
  input wire logic dsr_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // far end echoes the line a cycle late, like a looped connector
  initial rxd_pin = 1'b1;
  always @(posedge clk) begin
    rxd_pin <= txd_pin;
  end
  assign cts_pin = cts_lvl;
  assign dsr_pin = dsr_lvl;
endmodule
